// ===== core/ddw_pkg.sv
// Shared constants, register map and types for the waveform mode controller
package ddw_pkg;

	// Clock and numeric widths
	localparam int unsigned    CLK_HZ      = 40_000_000;
	localparam longint unsigned MAX_FREQ_HZ = 10_000_000;
	localparam int unsigned    ACC_W       = 48;
	localparam int unsigned    SAMPLE_W    = 12;
	localparam int unsigned    ARB_DEPTH   = 16384;

	// Frequency word limits: word = f * 2^48 / f_clk
	localparam logic [47:0] FREQ_WORD_MAX   = 48'((64'h1 << ACC_W) / (64'(CLK_HZ) / MAX_FREQ_HZ));
	localparam longint unsigned FREQ_HZ_RESET = 1000;
	localparam logic [47:0] FREQ_WORD_RESET = 48'(((64'h1 << ACC_W) * FREQ_HZ_RESET) / 64'(CLK_HZ));

	// Duty in hundredths of a percent
	localparam logic [13:0] DUTY_FULL  = 14'h2710;
	localparam logic [13:0] DUTY_RESET = 14'h1388;

	// Burst count and internal trigger
	localparam logic [15:0] BURST_RESET     = 16'h0005;
	localparam int unsigned TRIG_HZ_RESET    = 100;
	localparam logic [31:0] TRIG_PERIOD_RESET = 32'(CLK_HZ / TRIG_HZ_RESET);

	// Sample codes
	localparam logic [11:0] MID_CODE = 12'h800;
	localparam logic [11:0] POS_CODE = 12'hfff;
	localparam logic [11:0] NEG_CODE = 12'h001;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_FREQ_LO  = 8'h04;
	localparam logic [7:0] OFS_FREQ_HI  = 8'h08;
	localparam logic [7:0] OFS_DUTY     = 8'h0c;
	localparam logic [7:0] OFS_BURST    = 8'h10;
	localparam logic [7:0] OFS_TRIG_PER = 8'h14;
	localparam logic [7:0] OFS_PHASE    = 8'h18;
	localparam logic [7:0] OFS_STATUS   = 8'h1c;
	localparam logic [7:0] OFS_ARB_ADDR = 8'h20;
	localparam logic [7:0] OFS_ARB_DATA = 8'h24;

	// Control register fields
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned CTRL_SHAPE_LSB = 1;
	localparam int unsigned CTRL_INV_BIT   = 4;
	localparam int unsigned CTRL_MODE_LSB  = 5;
	localparam int unsigned CTRL_TSRC_BIT  = 7;
	localparam int unsigned CTRL_LINK_BIT  = 8;
	localparam int unsigned CTRL_PRIM_BIT  = 9;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SHAPE_SINE = 3'h0, SHAPE_SQUARE = 3'h1, SHAPE_RAMP = 3'h2,
		SHAPE_TRIANGLE = 3'h3, SHAPE_PULSE = 3'h4, SHAPE_ARB = 3'h5
	} ddw_shape_e;

	typedef enum logic [1:0] {
		MODE_CONT = 2'h0, MODE_TRIG = 2'h1, MODE_GATE = 2'h2, MODE_DC = 2'h3
	} ddw_mode_e;

	typedef enum logic [3:0] {
		ST_OFF = 4'h1, ST_WAIT = 4'h2, ST_RUN = 4'h4, ST_DC = 4'h8
	} ddw_state_e;

	// Settings shared between linked channels
	typedef struct packed {
		logic [47:0] freq;
		logic [13:0] duty;
		logic [15:0] phase;
	} ddw_link_s;

endpackage

// ===== core/ddw_shape_gen.sv
// Combinational waveform shaper: phase index to sample code
`timescale 1ns/1ps
module ddw_shape_gen
	import ddw_pkg::*;
(
	input  wire logic [15:0] phase_in,
	input  wire ddw_shape_e  shape_in,
	input  wire logic [13:0] duty_in,
	input  wire logic [11:0] arb_in,
	output logic      [11:0] sample_out
);

	logic [31:0] sine_prod;
	logic [10:0] sine_mag;
	logic [14:0] tri_fold;
	logic        pulse_high;

	// Parabolic half-wave approximation of sine keeps the design free of a table
	always_comb begin
		sine_prod  = 32'(phase_in[14:0]) * (32'h8000 - 32'(phase_in[14:0]));
		sine_mag   = sine_prod[28] ? 11'h7ff : sine_prod[27:17];
		tri_fold   = phase_in[15] ? ~phase_in[14:0] : phase_in[14:0];
		pulse_high = (32'(phase_in) * 32'h2710) < (32'(duty_in) << 16);
		unique case (shape_in)
			SHAPE_SINE:     sample_out = phase_in[15] ? MID_CODE - 12'(sine_mag) : MID_CODE + 12'(sine_mag);
			SHAPE_SQUARE:   sample_out = phase_in[15] ? NEG_CODE : POS_CODE;
			SHAPE_RAMP:     sample_out = phase_in[15:4];
			SHAPE_TRIANGLE: sample_out = tri_fold[14:3];
			SHAPE_PULSE:    sample_out = pulse_high ? POS_CODE : NEG_CODE;
			SHAPE_ARB:      sample_out = arb_in;
			default:        sample_out = MID_CODE;
		endcase
	end

endmodule

// ===== core/ddw_tick_timer.sv
// Periodic tick generator for the internal trigger source
`timescale 1ns/1ps
module ddw_tick_timer (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        enable_in,
	input  wire logic [31:0] period_in,
	output logic             tick_out
);

	logic [31:0] count;
	logic [31:0] next_count;
	logic        next_tick;

	// Count restarts whenever the source is idle, so the first tick is a full period away
	always_comb begin
		next_count = count + 32'h1;
		next_tick  = 1'b0;
		if (!enable_in) begin
			next_count = 32'h0;
		end else if (next_count >= period_in) begin
			next_count = 32'h0;
			next_tick  = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count    <= 32'h0;
			tick_out <= 1'b0;
		end else begin
			count    <= next_count;
			tick_out <= next_tick;
		end
	end

endmodule

// ===== core/ddw_wave_ctrl.sv
// Waveform mode controller: register slave, run control and sample output
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ddw_wave_ctrl
	import ddw_pkg::*;
#(
	parameter logic [31:0] TRIG_PERIOD_DEFAULT = TRIG_PERIOD_RESET
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Trigger or gate level from the backplane
	input  wire logic        backplane_trigger_source_in,
	// Settings from the primary channel, and our own settings for secondaries
	input  wire ddw_link_s   primary_channel_in,
	output ddw_link_s        secondary_channel_out,
	// DAC side
	output logic [11:0]      sample_out,
	output logic             output_active_out
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        aw_have, w_have;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        next_aw_have, next_w_have;
	logic [7:0]  next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic        do_write;
	logic        addr_ok;

	logic [31:0] ctrl, freq_lo, freq_hi, duty, burst, trig_per, phase, arb_addr;
	logic [31:0] next_ctrl, next_freq_lo, next_freq_hi, next_duty, next_burst;
	logic [31:0] next_trig_per, next_phase, next_arb_addr;
	logic        arb_we;
	logic [31:0] wval;

	ddw_state_e  state, next_state;
	ddw_mode_e   run_mode, next_run_mode;
	logic [47:0] acc, next_acc;
	logic [15:0] remaining, next_remaining;
	logic        trig_prev;
	logic [15:0] phase_d, next_phase_d;
	logic        run_d, next_run_d;
	logic        inv_d, next_inv_d;
	logic [11:0] next_sample;
	logic        next_active;
	ddw_link_s   next_link;

	logic        out_en, inv, link_en, primary, tsrc_bus;
	ddw_mode_e   mode;
	ddw_shape_e  shape;
	ddw_link_s   own_set, eff_set;
	logic [48:0] acc_sum;
	logic [15:0] pidx;
	logic        int_tick, trig_event, gate_on, timer_en;
	logic [11:0] arb_mem [0:ARB_DEPTH-1];
	logic [11:0] arb_q;
	logic [11:0] shaped;

	assign s_axi_awready = awready;
	assign s_axi_wready  = wready;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_arready = arready;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rdata   = rdata;
	assign s_axi_rresp   = rresp;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes: address and data caught in either order, one at a time

	assign do_write = aw_have && w_have && !bvalid;

	always_comb begin
		next_awready = awready;
		next_wready  = wready;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_arready = arready;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		next_aw_have = aw_have;
		next_w_have  = w_have;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		if (s_axi_awvalid && awready) begin
			next_awready = 1'b0;
			next_aw_have = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready) begin
			next_wready = 1'b0;
			next_w_have = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_have = 1'b0;
			next_w_have  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (aw_addr <= OFS_ARB_DATA && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid  = 1'b0;
			next_awready = 1'b1;
			next_wready  = 1'b1;
		end
		if (s_axi_arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = addr_ok ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr)
				OFS_CTRL:     next_rdata = ctrl;
				OFS_FREQ_LO:  next_rdata = freq_lo;
				OFS_FREQ_HI:  next_rdata = freq_hi;
				OFS_DUTY:     next_rdata = duty;
				OFS_BURST:    next_rdata = burst;
				OFS_TRIG_PER: next_rdata = trig_per;
				OFS_PHASE:    next_rdata = phase;
				OFS_STATUS:   next_rdata = {remaining, 12'h0, state == ST_DC, state == ST_WAIT,
					state == ST_RUN, output_active_out};
				OFS_ARB_ADDR: next_rdata = arb_addr;
				default:      next_rdata = 32'h0;
			endcase
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
	end

	assign addr_ok = s_axi_araddr <= OFS_ARB_DATA && s_axi_araddr[1:0] == 2'h0;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= RESP_OKAY;
			aw_have <= 1'b0;
			w_have  <= 1'b0;
			aw_addr <= 8'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
			aw_have <= next_aw_have;
			w_have  <= next_w_have;
			aw_addr <= next_aw_addr;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Settings registers; out-of-range freq, duty, burst and trig_per values are refused, old value kept; ctrl keeps only its old shape field

	always_comb begin
		next_ctrl     = ctrl;
		next_freq_lo  = freq_lo;
		next_freq_hi  = freq_hi;
		next_duty     = duty;
		next_burst    = burst;
		next_trig_per = trig_per;
		next_phase    = phase;
		next_arb_addr = arb_addr;
		arb_we        = 1'b0;
		wval          = 32'h0;
		if (do_write) begin
			unique case (aw_addr)
				OFS_CTRL: begin
					wval = merge(ctrl, w_data, w_strb) & 32'h0000_03ff;
					if (state == ST_DC || wval[CTRL_SHAPE_LSB +: 3] > SHAPE_ARB) begin
						wval[CTRL_SHAPE_LSB +: 3] = ctrl[CTRL_SHAPE_LSB +: 3];
					end
					next_ctrl = wval;
				end
				OFS_FREQ_LO: begin
					wval = merge(freq_lo, w_data, w_strb);
					if ({freq_hi[15:0], wval} <= FREQ_WORD_MAX) begin
						next_freq_lo = wval;
					end
				end
				OFS_FREQ_HI: begin
					wval = merge(freq_hi, w_data, w_strb) & 32'h0000_ffff;
					if ({wval[15:0], freq_lo} <= FREQ_WORD_MAX) begin
						next_freq_hi = wval;
					end
				end
				OFS_DUTY: begin
					wval = merge(duty, w_data, w_strb);
					if (wval <= 32'(DUTY_FULL)) begin
						next_duty = wval;
					end
				end
				OFS_BURST: begin
					wval = merge(burst, w_data, w_strb);
					if (wval != 32'h0 && wval <= 32'h0000_ffff) begin
						next_burst = wval;
					end
				end
				OFS_TRIG_PER: begin
					wval = merge(trig_per, w_data, w_strb);
					if (wval != 32'h0) begin
						next_trig_per = wval;
					end
				end
				OFS_PHASE:    next_phase = merge(phase, w_data, w_strb) & 32'h0000_ffff;
				OFS_ARB_ADDR: next_arb_addr = merge(arb_addr, w_data, w_strb) & 32'h0000_3fff;
				OFS_ARB_DATA: begin
					arb_we        = 1'b1;
					next_arb_addr = (arb_addr + 32'h1) & 32'h0000_3fff;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl     <= 32'h0;
			freq_lo  <= FREQ_WORD_RESET[31:0];
			freq_hi  <= 32'(FREQ_WORD_RESET[47:32]);
			duty     <= 32'(DUTY_RESET);
			burst    <= 32'(BURST_RESET);
			trig_per <= TRIG_PERIOD_DEFAULT;
			phase    <= 32'h0;
			arb_addr <= 32'h0;
		end else begin
			ctrl     <= next_ctrl;
			freq_lo  <= next_freq_lo;
			freq_hi  <= next_freq_hi;
			duty     <= next_duty;
			burst    <= next_burst;
			trig_per <= next_trig_per;
			phase    <= next_phase;
			arb_addr <= next_arb_addr;
		end
	end

	// Arbitrary waveform store; read one cycle ahead of the shaper stage
	always_ff @(posedge clk_in) begin
		if (arb_we) begin
			arb_mem[arb_addr[13:0]] <= w_data[11:0];
		end
		arb_q <= arb_mem[pidx[15:2]];
	end

	////////////////////////////////////////////////////////////////////////////
	// Decoded controls and linked settings

	assign out_en   = ctrl[CTRL_EN_BIT];
	assign shape    = ddw_shape_e'(ctrl[CTRL_SHAPE_LSB +: 3]);
	assign inv      = ctrl[CTRL_INV_BIT];
	assign mode     = ddw_mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
	assign tsrc_bus = ctrl[CTRL_TSRC_BIT];
	assign link_en  = ctrl[CTRL_LINK_BIT];
	assign primary  = ctrl[CTRL_PRIM_BIT];
	assign own_set  = '{freq: {freq_hi[15:0], freq_lo}, duty: duty[13:0], phase: phase[15:0]};
	// A linked secondary runs on the lowest-slot channel's settings
	assign eff_set  = (link_en && !primary) ? primary_channel_in : own_set;

	// Phase index is offset by the start phase, so a wrap lands on the start point
	assign acc_sum  = {1'b0, acc} + {1'b0, eff_set.freq};
	assign pidx     = acc[47:32] + eff_set.phase;

	// Internal ticks only count in trigger mode with the internal source selected
	assign timer_en   = out_en && mode == MODE_TRIG && !tsrc_bus;
	assign trig_event = tsrc_bus ? (backplane_trigger_source_in && !trig_prev) : int_tick;
	assign gate_on    = backplane_trigger_source_in;

	ddw_tick_timer u_timer (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.enable_in (timer_en),
		.period_in (trig_per),
		.tick_out  (int_tick)
	);

	ddw_shape_gen u_shape (
		.phase_in   (phase_d),
		.shape_in   (shape),
		.duty_in    (eff_set.duty),
		.arb_in     (arb_q),
		.sample_out (shaped)
	);

	////////////////////////////////////////////////////////////////////////////
	// Run control: a mode change drops to OFF for one cycle and then re-enters

	always_comb begin
		next_state     = state;
		next_run_mode  = run_mode;
		next_acc       = acc;
		next_remaining = remaining;
		next_phase_d   = pidx;
		next_run_d     = state == ST_RUN;
		next_inv_d     = inv;
		next_active    = out_en;
		next_link      = own_set;
		unique case (state)
			ST_OFF: begin
				next_acc = 48'h0;
				if (out_en) begin
					next_run_mode = mode;
					unique case (mode)
						MODE_CONT: next_state = ST_RUN;
						MODE_DC:   next_state = ST_DC;
						default:   next_state = ST_WAIT;
					endcase
				end
			end
			ST_WAIT: begin
				next_acc = 48'h0;
				if (!out_en || mode != run_mode) begin
					next_state = ST_OFF;
				end else if (run_mode == MODE_TRIG && trig_event) begin
					next_state     = ST_RUN;
					next_remaining = burst[15:0];
				end else if (run_mode == MODE_GATE && gate_on) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				next_acc = acc_sum[47:0];
				if (!out_en || mode != run_mode) begin
					next_state = ST_OFF;
				end else if (acc_sum[48]) begin
					// Period boundary: decide on whole periods only
					if (run_mode == MODE_TRIG) begin
						next_remaining = remaining - 16'h1;
						if (remaining <= 16'h1) begin
							next_state = ST_WAIT;
							next_acc   = 48'h0;
						end
					end else if (run_mode == MODE_GATE && !gate_on) begin
						next_state = ST_WAIT;
						next_acc   = 48'h0;
					end
				end
			end
			ST_DC: begin
				next_acc = 48'h0;
				if (!out_en || mode != run_mode) begin
					next_state = ST_OFF;
				end
			end
		endcase
		// Idle and DC both present the zero-volt code; offset is analog
		next_sample = run_d ? (inv_d ? 12'(13'h1000 - 13'(shaped)) : shaped) : MID_CODE;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state                 <= ST_OFF;
			run_mode              <= MODE_CONT;
			acc                   <= 48'h0;
			remaining             <= 16'h0;
			trig_prev             <= 1'b0;
			phase_d               <= 16'h0;
			run_d                 <= 1'b0;
			inv_d                 <= 1'b0;
			sample_out            <= MID_CODE;
			output_active_out     <= 1'b0;
			secondary_channel_out <= '0;
		end else begin
			state                 <= next_state;
			run_mode              <= next_run_mode;
			acc                   <= next_acc;
			remaining             <= next_remaining;
			trig_prev             <= backplane_trigger_source_in;
			phase_d               <= next_phase_d;
			run_d                 <= next_run_d;
			inv_d                 <= next_inv_d;
			sample_out            <= next_sample;
			output_active_out     <= next_active;
			secondary_channel_out <= next_link;
		end
	end

endmodule

// ===== tb/ddw_wave_ctrl_assertions.sv
// Port-level timing checks for the waveform mode controller
`timescale 1ns/1ps
module ddw_wave_ctrl_assertions
	import ddw_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [11:0] sample_out,
	input wire logic        output_active_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Both write channels taken at one edge, and a read address taken
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (wr_both |-> ##2 s_axi_bvalid)
		else $error("write response not two edges after take");
	a_write_busy: assert property (wr_both |=> !s_axi_awready && !s_axi_wready)
		else $error("write channels still ready after take");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not one edge after take");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_unmapped_read: assert property ((rd_take and s_axi_araddr > 8'h24) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_idle_mid: assert property ((!output_active_out) [*4] |-> sample_out == MID_CODE)
		else $error("sample not mid-scale while disabled");
	// Pipeline keeps the output quiet for two edges after switch-on
	a_start_mid: assert property ($rose(output_active_out) |-> sample_out == MID_CODE ##1 sample_out == MID_CODE)
		else $error("sample moved too early after enable");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ddw_wave_ctrl ddw_wave_ctrl_assertions chk_u (.clk_in, .rst_in, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_out, .output_active_out);

// ===== tb/ddw_dac_model.sv
// Behavioural DAC: counts samples away from the zero-volt code
`timescale 1ns/1ps
module ddw_dac_model
	import ddw_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        clr_in,
	input  wire logic [11:0] code_in,
	output logic      [31:0] count_out
);
	// Unknown codes count too, so a garbled sample is never hidden
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_out <= 32'h0;
		end else if (clr_in) begin
			count_out <= 32'h0;
		end else if (code_in !== MID_CODE) begin
			count_out <= count_out + 32'h1;
		end
	end
endmodule

// ===== tb/ddw_wave_ctrl_tb_top.sv
// Register-level regression of the waveform mode controller
`timescale 1ns/1ps
module ddw_wave_ctrl_tb_top
	import ddw_pkg::*;
;
	logic clk_in, rst_in, awvalid, wvalid, bready, arvalid, rready, bp, clr;
	logic awready, wready, bvalid, arready, rvalid, active;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, cnt, d;
	logic [1:0] bresp, rresp, r;
	logic [11:0] smp;
	ddw_link_s prim, sec;
	int err_total, cmp_count;
	ddw_wave_ctrl #(.TRIG_PERIOD_DEFAULT(32'h28)) dut_u (.clk_in, .rst_in, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.backplane_trigger_source_in(bp), .primary_channel_in(prim), .secondary_channel_out(sec),
		.sample_out(smp), .output_active_out(active));
	ddw_dac_model dac_u (.clk_in, .rst_in, .clr_in(clr), .code_in(smp), .count_out(cnt));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and time-zero values
	initial begin
		clk_in = 0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial begin
		{rst_in, awvalid, wvalid, bready, arvalid, rready, bp, clr} = 8'h80;
		{awaddr, araddr, wdata} = 48'h0;
		prim = '{48'h1234, 14'h1388, 16'h8000};
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge clk_in);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!(awready && wready));
		do @(posedge clk_in); while (!bvalid);
		bready <= 0;
		chk("bresp", bresp, RESP_OKAY);
		// One idle edge so a following call never re-raises bready in the same step
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge clk_in); while (!arready);
		arvalid <= 0;
		do @(posedge clk_in); while (!rvalid);
		rready <= 0;
		v = rdata;
		rs = rresp;
		@(posedge clk_in);
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a, d, r);
		chk(n, d, e);
	endtask
	task automatic burst_pulse();
		clr <= 1;
		bp <= 1;
		@(posedge clk_in);
		{clr, bp} <= 2'h0;
		repeat (30) @(posedge clk_in);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		complete_run();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 0;
		@(posedge clk_in);
		rchk("ctrl", OFS_CTRL, 32'h0);
		rchk("duty", OFS_DUTY, 32'(DUTY_RESET));
		rchk("burst", OFS_BURST, 32'(BURST_RESET));
		rchk("freq lo", OFS_FREQ_LO, FREQ_WORD_RESET[31:0]);
		rchk("trig per", OFS_TRIG_PER, 32'h28);
		rd(8'h28, d, r);
		chk("unmapped", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
		// Out-of-range writes must leave old values in place
		wr(OFS_FREQ_LO, 32'h0);
		wr(OFS_FREQ_HI, 32'h4000);
		wr(OFS_FREQ_HI, 32'h4001);
		rchk("freq hi", OFS_FREQ_HI, 32'h4000);
		wr(OFS_DUTY, 32'h2711);
		rchk("duty over", OFS_DUTY, 32'(DUTY_RESET));
		wr(OFS_BURST, 32'h0);
		rchk("burst zero", OFS_BURST, 32'h5);
		wr(OFS_CTRL, 32'hc);
		rchk("bad shape", OFS_CTRL, 32'h0);
		// Continuous square, then off
		wr(OFS_CTRL, 32'h3);
		rchk("status on", OFS_STATUS, 32'h3);
		wr(OFS_CTRL, 32'h0);
		repeat (6) @(posedge clk_in);
		chk("off code", 32'(smp), 32'(MID_CODE));
		// Bus-triggered bursts of two four-clock periods, twice
		wr(OFS_BURST, 32'h2);
		wr(OFS_CTRL, 32'ha3);
		repeat (2) begin
			burst_pulse();
			chk("burst len", cnt, 32'h8);
		end
		// Internal source repeats bursts on its own
		wr(OFS_CTRL, 32'h23);
		clr <= 1;
		@(posedge clk_in);
		clr <= 0;
		repeat (200) @(posedge clk_in);
		chk("internal", 32'(cnt >= 32'h18), 32'h1);
		// Gate mode emits whole periods only
		wr(OFS_CTRL, 32'h43);
		{clr, bp} <= 2'h3;
		// Clear ends before the first gated sample, so only whole periods are counted
		repeat (3) @(posedge clk_in);
		clr <= 0;
		repeat (7) @(posedge clk_in);
		bp <= 0;
		repeat (20) @(posedge clk_in);
		chk("gate whole", {cnt[1:0], 1'(cnt == 0)}, 3'h0);
		// Full-duty pulse at a low rate, inverted and plain
		wr(OFS_FREQ_HI, 32'h100);
		wr(OFS_DUTY, 32'h2710);
		wr(OFS_CTRL, 32'h19);
		repeat (8) @(posedge clk_in);
		chk("inverted", 32'(smp), 32'(NEG_CODE));
		wr(OFS_CTRL, 32'h9);
		repeat (8) @(posedge clk_in);
		chk("plain", 32'(smp), 32'(POS_CODE));
		chk("own duty", 32'(sec.duty), 32'h2710);
		// Linked secondary restarts on the primary's half-period start phase and half duty
		wr(OFS_CTRL, 32'h108);
		wr(OFS_CTRL, 32'h109);
		repeat (8) @(posedge clk_in);
		chk("linked", 32'(smp), 32'(NEG_CODE));
		// Stored word at the linked start phase reaches the output
		wr(OFS_ARB_ADDR, 32'h2000);
		wr(OFS_ARB_DATA, 32'h123);
		rchk("arb addr", OFS_ARB_ADDR, 32'h2001);
		wr(OFS_CTRL, 32'h10b);
		repeat (8) @(posedge clk_in);
		chk("arb", 32'(smp), 32'h123);
		// Shape change ignored in DC output
		wr(OFS_CTRL, 32'h61);
		wr(OFS_CTRL, 32'h63);
		rchk("dc shape", OFS_CTRL, 32'h61);
		rd(OFS_STATUS, d, r);
		chk("dc state", d & 32'h8, 32'h8);
		complete_run();
	end
endmodule
